// ### src/mcs_pkg.sv
// Constants, types and the step table of the machine cycle bus sequencer.
// Assumes one processor clock, one T state per clock and no wait states.
package mcs_pkg;

    // Bus widths of the processor.
    localparam int MCS_ADDR_W = 16;
    localparam int MCS_DATA_W = 8;

    // One T state lasts one processor clock, rounded up to whole cycles.
    localparam int MCS_CLK_PERIOD_PS = 8000;
    localparam int MCS_T_STATE_PS = 8000;
    localparam int MCS_T_STATE_CYCLES = (MCS_T_STATE_PS + MCS_CLK_PERIOD_PS - 1) / MCS_CLK_PERIOD_PS;

    // Index of the last T state of a bus cycle and of an idle state.
    localparam logic [1:0] MCS_BUS_LAST_T = 2'h2;
    localparam logic [1:0] MCS_IDLE_LAST_T = 2'h0;

    // Step positions that the sequencer treats specially.
    localparam logic [3:0] MCS_STEP_FIRST = 4'h0;
    localparam logic [3:0] MCS_IDX_DISP_STEP = 4'h2;
    localparam logic [3:0] MCS_OPER_STEP_SHORT = 4'h1;
    localparam logic [3:0] MCS_OPER_STEP_LONG = 4'h2;
    localparam logic [3:0] MCS_JP_LOW_STEP = 4'h1;
    localparam logic [3:0] MCS_JP_END_STEP = 4'h3;
    localparam logic [3:0] MCS_BLK_WRITE_STEP = 4'h3;
    localparam logic [3:0] MCS_BLK_END_STEP = 4'h6;

    // Fixed byte values and the 16-bit program counter step.
    localparam logic [7:0] MCS_ZERO_PAGE = 8'h00;
    localparam logic [7:0] MCS_ONE = 8'h01;
    localparam logic [15:0] MCS_PC_STEP = 16'h0001;

    typedef enum logic [3:0] {
        MCS_IDX_INCDEC,
        MCS_PAIR_INCDEC,
        MCS_IXREG_INCDEC,
        MCS_IN_A_PORT,
        MCS_IN_REG_C,
        MCS_ZERO_PAGE_PORT_INPUT,
        MCS_BLOCK_INPUT,
        MCS_BLOCK_INPUT_REPEAT,
        MCS_JP_ABS,
        MCS_JP_COND,
        MCS_JP_HL,
        MCS_JP_INDEX
    } mcs_instr_t;

    typedef enum logic [2:0] {
        MCS_K_FETCH1,
        MCS_K_FETCH2,
        MCS_K_MEM_READ,
        MCS_K_MEM_WRITE,
        MCS_K_IO_READ,
        MCS_K_IDLE,
        MCS_K_END
    } mcs_kind_t;

    typedef enum logic [2:0] {
        MCS_A_PC,
        MCS_A_BC,
        MCS_A_HL,
        MCS_A_INDEXED,
        MCS_A_PORT_ACC,
        MCS_A_PORT_ZERO,
        MCS_A_NONE
    } mcs_asel_t;

    typedef struct packed {
        mcs_kind_t kind;
        mcs_asel_t asel;
    } mcs_step_t;

    // Whole state of the sequencer, registered once per clock.
    typedef struct packed {
        logic busy;
        mcs_instr_t instr;
        logic [3:0] step;
        logic [1:0] tcnt;
        logic [15:0] pc;
        logic [15:0] pc_start;
        logic [15:0] bc;
        logic [15:0] hl;
        logic [15:0] index;
        logic [15:0] next_pc;
        logic [7:0] acc;
        logic [7:0] disp;
        logic [7:0] operand;
        logic [7:0] rdata;
        logic [7:0] tlow;
        logic cond;
        logic dec;
        logic [15:0] address;
        logic [7:0] data_out;
        logic data_oe;
        logic rd_n;
        logic wr_n;
        logic memory_request_n_n;
        logic io_request_n_n;
        logic m1_n;
        logic halt_n;
        logic status_n;
        logic done;
    } mcs_state_t;

    // Reset leaves every strobe inactive and the data bus released.
    localparam mcs_state_t MCS_STATE_RST = '{
        instr: MCS_IDX_INCDEC,
        rd_n: 1'b1, wr_n: 1'b1, memory_request_n_n: 1'b1, io_request_n_n: 1'b1,
        m1_n: 1'b1, halt_n: 1'b1, status_n: 1'b1,
        default: '0
    };

    // Ordered machine cycles of each instruction; a step past the list reads as end.
    function automatic mcs_step_t mcs_lookup(input mcs_instr_t instr, input logic [3:0] step);
        mcs_step_t r;
        r = '{kind: MCS_K_END, asel: MCS_A_NONE};
        if (step == 4'h0) begin
            r = '{kind: MCS_K_FETCH1, asel: MCS_A_PC};
        end else begin
            case (instr)
                MCS_IDX_INCDEC: begin
                    case (step)
                        4'h1: r = '{kind: MCS_K_FETCH2, asel: MCS_A_PC};
                        4'h2: r = '{kind: MCS_K_MEM_READ, asel: MCS_A_PC};
                        4'h3, 4'h4, 4'h6: r = '{kind: MCS_K_IDLE, asel: MCS_A_NONE};
                        4'h5: r = '{kind: MCS_K_MEM_READ, asel: MCS_A_INDEXED};
                        4'h7: r = '{kind: MCS_K_MEM_WRITE, asel: MCS_A_INDEXED};
                        default: r = '{kind: MCS_K_END, asel: MCS_A_NONE};
                    endcase
                end
                MCS_PAIR_INCDEC: begin
                    if (step == 4'h1) r = '{kind: MCS_K_IDLE, asel: MCS_A_NONE}; // [RULE7]
                end
                MCS_IXREG_INCDEC: begin
                    if (step == 4'h1) r = '{kind: MCS_K_FETCH2, asel: MCS_A_PC};
                    if (step == 4'h2) r = '{kind: MCS_K_IDLE, asel: MCS_A_NONE}; // [RULE8]
                end
                MCS_IN_A_PORT: begin
                    if (step == 4'h1) r = '{kind: MCS_K_MEM_READ, asel: MCS_A_PC};
                    if (step == 4'h2) r = '{kind: MCS_K_IO_READ, asel: MCS_A_PORT_ACC};
                end
                MCS_IN_REG_C: begin
                    if (step == 4'h1) r = '{kind: MCS_K_FETCH2, asel: MCS_A_PC};
                    if (step == 4'h2) r = '{kind: MCS_K_IO_READ, asel: MCS_A_BC};
                end
                MCS_ZERO_PAGE_PORT_INPUT: begin
                    if (step == 4'h1) r = '{kind: MCS_K_FETCH2, asel: MCS_A_PC};
                    if (step == 4'h2) r = '{kind: MCS_K_MEM_READ, asel: MCS_A_PC};
                    if (step == 4'h3) r = '{kind: MCS_K_IO_READ, asel: MCS_A_PORT_ZERO};
                end
                MCS_BLOCK_INPUT, MCS_BLOCK_INPUT_REPEAT: begin
                    if (step == 4'h1) r = '{kind: MCS_K_FETCH2, asel: MCS_A_PC};
                    if (step == 4'h2) r = '{kind: MCS_K_IO_READ, asel: MCS_A_BC};
                    if (step == 4'h3) r = '{kind: MCS_K_MEM_WRITE, asel: MCS_A_HL};
                    if (instr == MCS_BLOCK_INPUT_REPEAT && (step == 4'h4 || step == 4'h5)) begin
                        r = '{kind: MCS_K_IDLE, asel: MCS_A_NONE};
                    end
                end
                MCS_JP_ABS, MCS_JP_COND: begin
                    if (step == 4'h1 || step == 4'h2) r = '{kind: MCS_K_MEM_READ, asel: MCS_A_PC};
                end
                MCS_JP_INDEX: begin
                    if (step == 4'h1) r = '{kind: MCS_K_FETCH2, asel: MCS_A_PC};
                end
                default: r = '{kind: MCS_K_END, asel: MCS_A_NONE};
            endcase
        end
        return r;
    endfunction : mcs_lookup

endpackage : mcs_pkg

// ### src/mcs_sequencer.sv
// Machine cycle bus sequencer: plays the bus cycles of one instruction at a time.
// Assumes memory and I/O answer without wait states and hold data through T3.
// What this block does
// [RULE1] First cycle is a three-state fetch, read, memory, first-fetch, status low.
// [RULE2] Second fetch of prefixed instructions matches the first but status is high.
// [RULE3] Operand reads are three-state memory reads, first-fetch and status high.
// [RULE4] Idle states keep every strobe high and release the data bus.
// [RULE5] Indexed inc/dec: two fetches, displacement, two idles, read, idle, write.
// [RULE6] Memory write lasts three states with write and memory request low only.
// [RULE7] Register-pair inc/dec is one fetch followed by one idle state.
// [RULE8] Index-register inc/dec is two fetches followed by one idle state.
// [RULE9] Accumulator port input: operand read, then I/O read at accumulator and operand.
// [RULE10] Register-indirect port input: two fetches then one I/O read at BC.
// [RULE11] Zero-page port input: two fetches, operand read, I/O read with zero high byte.
// [RULE12] Single block input: two fetches, I/O read at BC, memory write at HL.
// [RULE13] Repeating block input adds two idles while counter is non-zero, then repeats.
// [RULE14] Repeating block input ends right after its write once counter is zero.
// [RULE15] Absolute jump: fetch, low target byte read, high byte read.
// [RULE16] False conditional jump stops after fetch and low byte read.
// [RULE17] True conditional jump runs all three cycles.
// [RULE18] Jump through HL completes within its single fetch.
// [RULE19] Jump through an index register completes after two fetches.
// [RULE20] Every T state and idle state lasts exactly one clock.
module mcs_sequencer
    import mcs_pkg::*;
#(
    parameter int ADDR_W = MCS_ADDR_W,
    parameter int DATA_W = MCS_DATA_W
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic start,
    input wire mcs_instr_t instr_sel,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] bc_in,
    input wire logic [15:0] hl_in,
    input wire logic [15:0] index_in,
    input wire logic [7:0] acc_in,
    input wire logic cond_in,
    input wire logic dec_in,
    input wire logic [7:0] data_in,
    output logic [15:0] address,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic rd_n,
    output logic wr_n,
    output logic memory_request_n,
    output logic io_request_n,
    output logic first_fetch_n,
    output logic halt_n,
    output logic status_n,
    output logic busy,
    output logic done,
    output logic [15:0] next_pc,
    output logic [7:0] read_data,
    output logic [15:0] bc_out,
    output logic [15:0] hl_out
);

    mcs_state_t mcs_state_reg;
    mcs_state_t mcs_state_next;
    logic [7:0] din_sync;

    // The bus logic is written for one byte of data and sixteen address lines.
    if (ADDR_W != 16 || DATA_W != 8 || MCS_T_STATE_CYCLES != 1) begin : g_chk
        $error("mcs_sequencer serves only a 16-bit address, 8-bit data, one clock per T state");
    end

    // Data pins come from outside devices and are synchronised before use.
    mcs_sync #(
        .WIDTH(8),
        .STAGES(2)
    ) u_din_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .async_in(data_in),
        .sync_out(din_sync)
    );

    // Next state: advance the T state, apply the effects of a finished cycle,
    // then set the bus for the position that the next clock enters. Outputs are
    // computed for the upcoming position so that pins and state stay aligned.
    always_comb begin
        mcs_state_t r;
        mcs_state_t s;
        mcs_step_t cur;
        mcs_step_t nxt;
        logic [1:0] last_t;
        r = mcs_state_reg;
        s = mcs_state_reg;
        s.done = 1'b0;
        cur = mcs_lookup(r.instr, r.step);
        nxt = mcs_step_t'{kind: MCS_K_IDLE, asel: MCS_A_NONE};
        last_t = (cur.kind == MCS_K_IDLE) ? MCS_IDLE_LAST_T : MCS_BUS_LAST_T; // [RULE20]
        if (!r.busy) begin
            if (start) begin
                s.busy = 1'b1;
                s.instr = instr_sel;
                s.step = MCS_STEP_FIRST; // [RULE1]
                s.tcnt = 2'h0;
                s.pc = pc_in;
                s.pc_start = pc_in;
                s.bc = bc_in;
                s.hl = hl_in;
                s.index = index_in;
                s.acc = acc_in;
                s.cond = cond_in;
                s.dec = dec_in;
            end
        end else if (r.tcnt != last_t) begin
            s.tcnt = r.tcnt + 2'h1; // [RULE20]
        end else begin
            // Effects of the cycle that ends with this clock.
            case (cur.kind)
                MCS_K_FETCH1, MCS_K_FETCH2: begin
                    s.pc = r.pc + MCS_PC_STEP;
                end
                MCS_K_MEM_READ: begin
                    s.rdata = din_sync;
                    if (cur.asel == MCS_A_PC) begin
                        s.pc = r.pc + MCS_PC_STEP;
                    end
                    if (r.instr == MCS_IDX_INCDEC && r.step == MCS_IDX_DISP_STEP) begin
                        s.disp = din_sync;
                    end
                    if ((r.instr == MCS_IN_A_PORT && r.step == MCS_OPER_STEP_SHORT) ||
                        (r.instr == MCS_ZERO_PAGE_PORT_INPUT && r.step == MCS_OPER_STEP_LONG)) begin
                        s.operand = din_sync;
                    end
                    if ((r.instr == MCS_JP_ABS || r.instr == MCS_JP_COND) &&
                        r.step == MCS_JP_LOW_STEP) begin
                        s.tlow = din_sync;
                    end
                end
                MCS_K_IO_READ: begin
                    s.rdata = din_sync;
                    if (r.instr == MCS_BLOCK_INPUT || r.instr == MCS_BLOCK_INPUT_REPEAT) begin
                        s.bc[15:8] = r.bc[15:8] - MCS_ONE;
                    end
                end
                MCS_K_MEM_WRITE: begin
                    if (r.instr == MCS_BLOCK_INPUT || r.instr == MCS_BLOCK_INPUT_REPEAT) begin
                        s.hl = r.dec ? (r.hl - MCS_PC_STEP) : (r.hl + MCS_PC_STEP);
                    end
                end
                default: begin
                    s.rdata = r.rdata;
                end
            endcase
            s.step = r.step + 4'h1;
            s.tcnt = 2'h0;
            // A spent counter skips the trailing idle states.
            if (r.instr == MCS_BLOCK_INPUT_REPEAT && r.step == MCS_BLK_WRITE_STEP &&
                r.bc[15:8] == MCS_ZERO_PAGE) begin
                s.step = MCS_BLK_END_STEP; // [RULE14]
            end
            // A false condition drops the high target byte read.
            if (r.instr == MCS_JP_COND && r.step == MCS_JP_LOW_STEP && !r.cond) begin
                s.step = MCS_JP_END_STEP; // [RULE16]
            end
            nxt = mcs_lookup(r.instr, s.step);
            if (nxt.kind == MCS_K_END) begin
                if (r.instr == MCS_BLOCK_INPUT_REPEAT && r.bc[15:8] != MCS_ZERO_PAGE) begin
                    s.step = MCS_STEP_FIRST; // [RULE13]
                    s.pc = r.pc_start;
                end else begin
                    s.busy = 1'b0;
                    s.done = 1'b1;
                    case (r.instr)
                        MCS_JP_ABS: s.next_pc = {din_sync, r.tlow}; // [RULE15]
                        MCS_JP_COND: s.next_pc = r.cond ? {din_sync, r.tlow} : s.pc; // [RULE17]
                        MCS_JP_HL: s.next_pc = r.hl; // [RULE18]
                        MCS_JP_INDEX: s.next_pc = r.index; // [RULE19]
                        default: s.next_pc = s.pc;
                    endcase
                end
            end
        end
        // Bus levels of the position entered at the next clock.
        nxt = mcs_step_t'{kind: MCS_K_IDLE, asel: MCS_A_NONE};
        if (s.busy) begin
            nxt = mcs_lookup(s.instr, s.step);
        end
        s.rd_n = 1'b1; // [RULE4]
        s.wr_n = 1'b1;
        s.memory_request_n_n = 1'b1;
        s.io_request_n_n = 1'b1;
        s.m1_n = 1'b1;
        s.halt_n = 1'b1;
        s.status_n = 1'b1;
        s.data_oe = 1'b0;
        case (nxt.kind)
            MCS_K_FETCH1: begin
                s.rd_n = 1'b0; // [RULE1]
                s.memory_request_n_n = 1'b0;
                s.m1_n = 1'b0;
                s.status_n = 1'b0;
            end
            MCS_K_FETCH2: begin
                s.rd_n = 1'b0; // [RULE2]
                s.memory_request_n_n = 1'b0;
                s.m1_n = 1'b0;
            end
            MCS_K_MEM_READ: begin
                s.rd_n = 1'b0; // [RULE3]
                s.memory_request_n_n = 1'b0;
            end
            MCS_K_MEM_WRITE: begin
                s.wr_n = 1'b0; // [RULE6]
                s.memory_request_n_n = 1'b0;
                s.data_oe = 1'b1;
                if (s.instr == MCS_IDX_INCDEC) begin
                    s.data_out = s.dec ? (s.rdata - MCS_ONE) : (s.rdata + MCS_ONE); // [RULE5]
                end else begin
                    s.data_out = s.rdata; // [RULE12]
                end
            end
            MCS_K_IO_READ: begin
                s.rd_n = 1'b0; // [RULE9]
                s.io_request_n_n = 1'b0;
            end
            default: begin
                s.data_oe = 1'b0;
            end
        endcase
        // Address source; idle states simply hold the last address.
        case (nxt.asel)
            MCS_A_PC: s.address = s.pc;
            MCS_A_BC: s.address = s.bc; // [RULE10]
            MCS_A_HL: s.address = s.hl;
            MCS_A_INDEXED: s.address = s.index + {{8{s.disp[7]}}, s.disp};
            MCS_A_PORT_ACC: s.address = {s.acc, s.operand};
            MCS_A_PORT_ZERO: s.address = {MCS_ZERO_PAGE, s.operand}; // [RULE11]
            default: s.address = r.address;
        endcase
        mcs_state_next = s;
    end

    // The whole state is one register.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mcs_state_reg <= MCS_STATE_RST;
        end else begin
            mcs_state_reg <= mcs_state_next;
        end
    end

    // All outputs come straight from the state register.
    assign address = mcs_state_reg.address;
    assign data_out = mcs_state_reg.data_out;
    assign data_oe = mcs_state_reg.data_oe;
    assign rd_n = mcs_state_reg.rd_n;
    assign wr_n = mcs_state_reg.wr_n;
    assign memory_request_n = mcs_state_reg.memory_request_n_n;
    assign io_request_n = mcs_state_reg.io_request_n_n;
    assign first_fetch_n = mcs_state_reg.m1_n;
    assign halt_n = mcs_state_reg.halt_n;
    assign status_n = mcs_state_reg.status_n;
    assign busy = mcs_state_reg.busy;
    assign done = mcs_state_reg.done;
    assign next_pc = mcs_state_reg.next_pc;
    assign read_data = mcs_state_reg.rdata;
    assign bc_out = mcs_state_reg.bc;
    assign hl_out = mcs_state_reg.hl;

    // Checks on the bus sequence.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_fetch_start: assert property (start && !busy |=> (!first_fetch_n && !status_n &&
        !rd_n && !memory_request_n && wr_n && io_request_n && halt_n)[*3]) // [RULE1]
        else $error("first fetch strobes wrong");
    a_second_fetch: assert property ($rose(status_n) && !first_fetch_n |->
        (!first_fetch_n && status_n && !rd_n && !memory_request_n)[*3]) // [RULE2]
        else $error("second fetch strobes wrong");
    a_operand_read: assert property (!rd_n && !memory_request_n && first_fetch_n |->
        status_n && wr_n && io_request_n) // [RULE3]
        else $error("operand read strobes wrong");
    a_idle_float: assert property (rd_n && wr_n |-> !data_oe && memory_request_n &&
        io_request_n && first_fetch_n && status_n) // [RULE4]
        else $error("data bus driven in idle state");
    a_write_shape: assert property ($fell(wr_n) |-> (!wr_n && rd_n && !memory_request_n &&
        io_request_n && status_n && data_oe)[*3] ##1 wr_n) // [RULE6]
        else $error("memory write shape wrong");
    a_io_shape: assert property ($fell(io_request_n) |-> (!io_request_n && !rd_n &&
        memory_request_n)[*3] ##1 io_request_n) // [RULE9]
        else $error("I/O read shape wrong");
    a_zero_page: assert property (!io_request_n &&
        mcs_state_reg.instr == MCS_ZERO_PAGE_PORT_INPUT |-> address[15:8] == 8'h00) // [RULE11]
        else $error("zero page high byte not zero");
    a_pair_length: assert property (start && !busy && instr_sel == MCS_PAIR_INCDEC |=>
        busy[*4] ##1 (done && !busy)) // [RULE7]
        else $error("pair inc/dec length wrong");
    a_ixreg_length: assert property (start && !busy && instr_sel == MCS_IXREG_INCDEC |=>
        busy[*7] ##1 done) // [RULE8]
        else $error("index inc/dec length wrong");
    a_jp_hl: assert property (start && !busy && instr_sel == MCS_JP_HL |=>
        busy[*3] ##1 (done && next_pc == $past(hl_out))) // [RULE18]
        else $error("jump through HL wrong");
    a_jp_false: assert property (start && !busy && instr_sel == MCS_JP_COND && !cond_in |=>
        ##6 done) // [RULE16]
        else $error("false conditional jump length wrong");
    a_idx_length: assert property (start && !busy && instr_sel == MCS_IDX_INCDEC |=>
        ##18 done) // [RULE5]
        else $error("indexed inc/dec length wrong");

    c_block_repeat: cover property (mcs_state_reg.instr == MCS_BLOCK_INPUT_REPEAT &&
        $rose(first_fetch_n) ##[1:20] $fell(first_fetch_n));
    c_jump_true: cover property (done && mcs_state_reg.instr == MCS_JP_COND && mcs_state_reg.cond);
    c_idx_done: cover property (done && mcs_state_reg.instr == MCS_IDX_INCDEC);
    c_zero_page: cover property (done && mcs_state_reg.instr == MCS_ZERO_PAGE_PORT_INPUT);

endmodule : mcs_sequencer

// ### src/mcs_sync.sv
// Multi-stage synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to ref_clk; only the last stage is read outside.
module mcs_sync #(
    parameter int WIDTH = 8,
    parameter int STAGES = 2
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [STAGES-1:0][WIDTH-1:0] chain_reg;

    // Fewer than two stages would let metastability reach the logic.
    if (STAGES < 2) begin : g_chk
        $error("mcs_sync needs at least two stages");
    end

    // Each stage feeds only the next one.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_reg[STAGES-1];

endmodule : mcs_sync

// ### tb/mcs_mem_model.sv
// Memory and I/O space on the far side of the sequencer's bus.
// Assumes bytes are only driven while rd_n is low; every byte is a function of the address.
module mcs_mem_model (
    input wire logic ref_clk,
    input wire logic [15:0] address,
    input wire logic rd_n,
    input wire logic memory_request_n,
    input wire logic io_request_n,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] last_reg = 8'h00;
    // Released pins toggle every cycle, so a stale byte can never pass for a read.
    always_comb begin
        if (!rd_n && !memory_request_n)
            data_in = address[7:0] ^ 8'h5a;
        else if (!rd_n && !io_request_n)
            data_in = address[7:0] ^ address[15:8] ^ 8'ha5;
        else
            data_in = ~last_reg;
    end
    // Remembers the last pin value for the toggling pattern.
    always @(posedge ref_clk) last_reg <= data_in;
endmodule : mcs_mem_model

// ### tb/tb_top.sv
// Self-checking bench of the machine cycle bus sequencer.
// Assumes the memory model answers with no wait states; inputs change on falling edges.
module tb_top import mcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, start, cond_in, dec_in, data_oe, rd_n, wr_n, memory_request_n;
    logic io_request_n, first_fetch_n, halt_n, status_n, busy, done;
    mcs_instr_t instr_sel;
    logic [15:0] pc_in, bc_in, hl_in, index_in, address, next_pc, bc_out, hl_out;
    logic [7:0] acc_in, data_in, data_out, read_data;
    int miscompares = 0;
    int total_checks = 0;
    logic [7:0] last_rd = 8'h00;
    mcs_sequencer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start),
        .instr_sel(instr_sel), .pc_in(pc_in), .bc_in(bc_in), .hl_in(hl_in),
        .index_in(index_in), .acc_in(acc_in), .cond_in(cond_in), .dec_in(dec_in),
        .data_in(data_in), .address(address), .data_out(data_out), .data_oe(data_oe),
        .rd_n(rd_n), .wr_n(wr_n), .memory_request_n(memory_request_n),
        .io_request_n(io_request_n), .first_fetch_n(first_fetch_n), .halt_n(halt_n),
        .status_n(status_n), .busy(busy), .done(done), .next_pc(next_pc),
        .read_data(read_data), .bc_out(bc_out), .hl_out(hl_out));
    mcs_mem_model mem (.ref_clk(ref_clk), .address(address), .rd_n(rd_n),
        .memory_request_n(memory_request_n), .io_request_n(io_request_n), .data_in(data_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    // Strobes {rd, wr, memory_request_n, io_request_n, first, halt, status, oe}; 1=fetch, R/X=read, D=idle.
    function automatic logic [7:0] strb(input byte c);
        case (c)
            "1": return 8'h54;
            "2": return 8'h56;
            "D": return 8'hfe;
            "P", "Z", "B": return 8'h6e;
            "H", "Y": return 8'h9f;
            default: return 8'h5e;
        endcase
    endfunction : strb
    // Plays one instruction from the done cycle of the previous one, checking every state.
    task automatic play(input mcs_instr_t ins, input string seq, input logic [16:0] tgt);
        logic [15:0] p = pc_in, a, bcv = bc_in, hlv = hl_in;
        logic [7:0] op = 8'h00, rb = 8'h00, wd;
        instr_sel = ins;
        start = 1'h1;
        @(negedge ref_clk);
        start = 1'h0;
        for (int i = 0; i < seq.len(); i++) begin
            if (seq[i] == "1") p = pc_in;
            case (seq[i])
                "P": a = {acc_in, op};
                "Z": a = {8'h00, op};
                "B": a = bcv;
                "H": a = hlv;
                "X", "Y": a = index_in + {{8{op[7]}}, op};
                default: a = p;
            endcase
            wd = (seq[i] == "Y") ? (dec_in ? rb - 8'h01 : rb + 8'h01) : rb;
            repeat ((seq[i] == "D") ? 1 : 3) begin
                chk({rd_n, wr_n, memory_request_n, io_request_n, first_fetch_n, halt_n,
                    status_n, data_oe}, strb(seq[i]));
                if (seq[i] != "D") chk(address, a);
                if (strb(seq[i]) == 8'h9f) chk(data_out, wd);
                @(negedge ref_clk);
            end
            if (seq[i] inside {"1", "2", "R"}) p = p + 16'h0001;
            if (seq[i] == "R") op = a[7:0] ^ 8'h5a;
            if (seq[i] == "X") rb = a[7:0] ^ 8'h5a;
            if (seq[i] inside {"P", "Z", "B"}) rb = a[7:0] ^ a[15:8] ^ 8'ha5;
            if (seq[i] inside {"R", "X", "P", "Z", "B"}) last_rd = (seq[i] == "R") ? op : rb;
            if (seq[i] == "H") begin
                bcv[15:8] = bcv[15:8] - 8'h01;
                hlv = dec_in ? hlv - 16'h0001 : hlv + 16'h0001;
            end
        end
        chk({busy, done}, 2'h1);
        chk(read_data, last_rd);
        chk(next_pc, tgt[16] ? tgt[15:0] : p);
        if (seq[seq.len() - 1] == "H") chk({bc_out, hl_out}, {bcv, hlv});
    endtask : play
    task automatic t_incdec();
        pc_in = 16'h1234;
        play(MCS_IDX_INCDEC, "12RDDXDY", '0);
        pc_in = 16'h00a0;
        dec_in = 1'h1;
        play(MCS_IDX_INCDEC, "12RDDXDY", '0);
        play(MCS_PAIR_INCDEC, "1D", '0);
        play(MCS_IXREG_INCDEC, "12D", '0);
    endtask : t_incdec
    task automatic t_ports_blocks();
        play(MCS_IN_A_PORT, "1RP", '0);
        play(MCS_IN_REG_C, "12B", '0);
        play(MCS_ZERO_PAGE_PORT_INPUT, "12RZ", '0);
        play(MCS_BLOCK_INPUT, "12BH", '0);
        dec_in = 1'h0;
        play(MCS_BLOCK_INPUT, "12BH", '0);
        play(MCS_BLOCK_INPUT_REPEAT, "12BHDD12BH", '0);
        bc_in = 16'h0110;
        play(MCS_BLOCK_INPUT_REPEAT, "12BH", '0);
    endtask : t_ports_blocks
    task automatic t_jumps();
        pc_in = 16'h2000;
        play(MCS_JP_ABS, "1RR", {1'h1, 8'h02 ^ 8'h5a, 8'h01 ^ 8'h5a});
        play(MCS_JP_COND, "1R", '0);
        cond_in = 1'h1;
        play(MCS_JP_COND, "1RR", {1'h1, 8'h02 ^ 8'h5a, 8'h01 ^ 8'h5a});
        play(MCS_JP_HL, "1", {1'h1, hl_in});
        play(MCS_JP_INDEX, "12", {1'h1, index_in});
    endtask : t_jumps
    // Free-running processor clock.
    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end
    // A hang counts as a mismatch and ends the run the normal way.
    initial begin
        #20000;
        miscompares++;
        finish_test();
    end
    // Instructions run back to back, each started in the done cycle of the one before.
    initial begin
        {sys_rst, start, cond_in, dec_in} = 4'h8;
        instr_sel = MCS_IDX_INCDEC;
        {pc_in, bc_in, hl_in, index_in, acc_in} = {16'h0000, 16'h0210, 16'h4000, 16'h8000, 8'hc3};
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'h0;
        chk({rd_n, wr_n, memory_request_n, io_request_n, first_fetch_n, halt_n, status_n,
            data_oe, busy, done}, 10'h3f8);
        t_incdec();
        t_ports_blocks();
        t_jumps();
        finish_test();
    end
endmodule : tb_top
